// ==== hdl/wear_meter_pkg.sv ====
// constants, register map and carriers for the load and travel maintenance meters
package wear_meter_pkg;

    // clock and time base
    localparam int unsigned     CLK_HZ          = 25_000_000;
    localparam int unsigned     SAMPLE_US       = 1000;
    localparam int unsigned     SAMPLE_CYCLES   = SAMPLE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned     SAVE_MIN        = 5;
    localparam longint unsigned SAVE_CYCLES     = longint'(SAVE_MIN) * 60 * longint'(CLK_HZ);
    localparam int unsigned     SAVE_W          = 33;

    // counter limits and units
    localparam logic [31:0]     LOAD_MAX        = 32'h7FFFFFFF;
    localparam logic [31:0]     REV_PER_UNIT    = 32'h00000064;

    // register byte offsets
    localparam logic [7:0]      OFS_CTRL        = 8'h00;
    localparam logic [7:0]      OFS_DIVISOR     = 8'h04;
    localparam logic [7:0]      OFS_THR_A       = 8'h08;
    localparam logic [7:0]      OFS_THR_B       = 8'h0C;
    localparam logic [7:0]      OFS_TRIP_THR    = 8'h10;
    localparam logic [7:0]      OFS_TOTAL_THR   = 8'h14;
    localparam logic [7:0]      OFS_LOAD        = 8'h18;
    localparam logic [7:0]      OFS_TRIP        = 8'h1C;
    localparam logic [7:0]      OFS_TOTAL       = 8'h20;
    localparam logic [7:0]      OFS_IRQ_STATUS  = 8'h24;
    localparam logic [7:0]      OFS_IRQ_CLEAR   = 8'h28;
    localparam logic [7:0]      OFS_IRQ_ENABLE  = 8'h2C;

    // control register fields
    localparam int unsigned     CTRL_AUTO_BIT   = 0;
    localparam int unsigned     CTRL_TRIPCLR_BIT = 1;

    // event bit positions in status, clear and enable
    localparam int unsigned     EV_LOAD_A       = 0;
    localparam int unsigned     EV_LOAD_B       = 1;
    localparam int unsigned     EV_TRIP         = 2;
    localparam int unsigned     EV_TOTAL        = 3;
    localparam int unsigned     EV_SAVED        = 4;
    localparam int unsigned     EV_W            = 5;

    // reset values
    localparam logic            RST_AUTO        = 1'b1;
    localparam logic [15:0]     RST_DIVISOR     = 16'h0001;
    localparam logic [31:0]     RST_THR_A       = 32'h00000000;
    localparam logic [31:0]     RST_THR_B       = 32'h00000000;
    localparam logic [31:0]     RST_TRIP_THR    = 32'h00002710;
    localparam logic [31:0]     RST_TOTAL_THR   = 32'h000186A0;
    localparam logic [EV_W-1:0] RST_IRQ_ENABLE  = 5'h00;

    // travel values handed to and from non-volatile storage
    typedef struct packed {
        logic [31:0] trip;
        logic [31:0] total;
    } travel_s;

endpackage

// ==== hdl/wear_meter.sv ====
// cumulative load meter and tripmeter/odometer with wishbone register access
`timescale 1ns/1ps
`default_nettype none

module wear_meter
    import wear_meter_pkg::*;
#(
    parameter int unsigned     SAMPLE_PERIOD = SAMPLE_CYCLES,
    parameter longint unsigned SAVE_PERIOD   = SAVE_CYCLES
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // wishbone slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic [31:0]        wb_dat_o,
    output logic               wb_ack_o,
    // motor measurements
    input  wire logic          motion_active_i,
    input  wire logic          latch_clear_input_i,
    input  wire logic [9:0]    load_factor_i,
    input  wire logic          rev_tick_i,
    // non-volatile storage
    input  wire logic          nvm_restore_i,
    input  wire travel_s       nvm_restore_data_i,
    output logic               nvm_save_o,
    output travel_s            nvm_save_data_o,
    // information
    output logic [EV_W-1:0]    info_o,
    output logic               irq_o
);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] dat,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res;
    endfunction

    logic                  auto_clear_r;
    logic [15:0]           divisor_r;
    logic [31:0]           thr_a_r;
    logic [31:0]           thr_b_r;
    logic [31:0]           trip_thr_r;
    logic [31:0]           total_thr_r;
    logic [31:0]           load_r;
    logic [31:0]           rem_r;
    logic [31:0]           rem_nxt;
    logic [31:0]           sample_cnt_r;
    logic [SAVE_W-1:0]     save_cnt_r;
    travel_s               travel_r;
    logic [EV_W-1:0]       status_r;
    logic [EV_W-1:0]       enable_r;
    logic [EV_W-1:0]       events;
    logic                  motion_q_r;
    logic                  latch_q_r;
    logic                  sample_tick;
    logic                  save_tick;
    logic                  load_clear;
    logic                  drain;
    logic [31:0]           div_eff;
    logic                  wr_access;
    logic                  trip_clear;

    // bus: one ack per request, given the cycle after the strobe is seen
    assign wr_access  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign trip_clear = wr_access && wb_adr_i == OFS_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_TRIPCLR_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
            unique case (wb_adr_i)
                OFS_CTRL:       wb_dat_o <= {31'h00000000, auto_clear_r};
                OFS_DIVISOR:    wb_dat_o <= {16'h0000, divisor_r};
                OFS_THR_A:      wb_dat_o <= thr_a_r;
                OFS_THR_B:      wb_dat_o <= thr_b_r;
                OFS_TRIP_THR:   wb_dat_o <= trip_thr_r;
                OFS_TOTAL_THR:  wb_dat_o <= total_thr_r;
                OFS_LOAD:       wb_dat_o <= load_r;
                OFS_TRIP:       wb_dat_o <= travel_r.trip;
                OFS_TOTAL:      wb_dat_o <= travel_r.total;
                OFS_IRQ_STATUS: wb_dat_o <= {27'h0000000, status_r};
                OFS_IRQ_ENABLE: wb_dat_o <= {27'h0000000, enable_r};
                default:        wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // software configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_clear_r <= RST_AUTO;
            divisor_r    <= RST_DIVISOR;
            thr_a_r      <= RST_THR_A;
            thr_b_r      <= RST_THR_B;
            trip_thr_r   <= RST_TRIP_THR;
            total_thr_r  <= RST_TOTAL_THR;
            enable_r     <= RST_IRQ_ENABLE;
        end else if (wr_access) begin
            unique case (wb_adr_i)
                OFS_CTRL: begin
                    if (wb_sel_i[0]) begin
                        auto_clear_r <= wb_dat_i[CTRL_AUTO_BIT];
                    end
                end
                OFS_DIVISOR:    divisor_r   <= 16'(merge_bytes({16'h0000, divisor_r}, wb_dat_i, wb_sel_i));
                OFS_THR_A:      thr_a_r     <= merge_bytes(thr_a_r, wb_dat_i, wb_sel_i);
                OFS_THR_B:      thr_b_r     <= merge_bytes(thr_b_r, wb_dat_i, wb_sel_i);
                OFS_TRIP_THR:   trip_thr_r  <= merge_bytes(trip_thr_r, wb_dat_i, wb_sel_i);
                OFS_TOTAL_THR:  total_thr_r <= merge_bytes(total_thr_r, wb_dat_i, wb_sel_i);
                OFS_IRQ_ENABLE: enable_r    <= EV_W'(merge_bytes({27'h0000000, enable_r}, wb_dat_i, wb_sel_i));
                default: begin
                end
            endcase
        end
    end

    // time base for load sampling
    always_ff @(posedge clk_i) begin
        if (rst_i || sample_tick) begin
            sample_cnt_r <= 32'h00000000;
        end else begin
            sample_cnt_r <= sample_cnt_r + 32'h00000001;
        end
    end
    assign sample_tick = sample_cnt_r == SAMPLE_PERIOD - 1;

    // edge detection of motion-active and latch-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            motion_q_r <= 1'b0;
            latch_q_r  <= 1'b0;
        end else begin
            motion_q_r <= motion_active_i;
            latch_q_r  <= latch_clear_input_i;
        end
    end
    assign load_clear = auto_clear_r ? (motion_active_i && !motion_q_r)
                                     : (latch_clear_input_i && !latch_q_r);

    // load is drained from the remainder one divisor per cycle; at the default sample period of SAMPLE_CYCLES it never backs up
    assign div_eff = (divisor_r == 16'h0000) ? 32'h00000001 : {16'h0000, divisor_r};
    assign drain   = rem_r >= div_eff;

    always_comb begin
        rem_nxt = rem_r;
        if (drain) begin
            rem_nxt = rem_nxt - div_eff;
        end
        if (sample_tick) begin
            rem_nxt = rem_nxt + {22'h000000, load_factor_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || load_clear) begin
            rem_r  <= 32'h00000000;
            load_r <= 32'h00000000;
        end else begin
            rem_r <= rem_nxt;
            if (drain && load_r != LOAD_MAX) begin
                load_r <= load_r + 32'h00000001;
            end
        end
    end

    // travel meters; restore brings back both values after power-up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            travel_r <= '0;
        end else if (nvm_restore_i) begin
            travel_r <= nvm_restore_data_i;
        end else begin
            if (trip_clear) begin
                travel_r.trip <= 32'h00000000;
            end else if (rev_tick_i) begin
                travel_r.trip <= travel_r.trip + 32'h00000001;
            end
            if (rev_tick_i) begin
                travel_r.total <= travel_r.total + 32'h00000001;
            end
        end
    end

    // periodic copy to storage; travel since the last copy is lost on power loss
    always_ff @(posedge clk_i) begin
        if (rst_i || save_tick) begin
            save_cnt_r <= '0;
        end else begin
            save_cnt_r <= save_cnt_r + SAVE_W'(1);
        end
    end
    assign save_tick = save_cnt_r == SAVE_W'(SAVE_PERIOD - 1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nvm_save_o      <= 1'b0;
            nvm_save_data_o <= '0;
        end else begin
            nvm_save_o <= save_tick;
            if (save_tick) begin
                nvm_save_data_o <= travel_r;
            end
        end
    end

    // information levels; a load threshold (A or B) of zero switches its comparison off
    always_comb begin
        events            = '0;
        events[EV_LOAD_A] = thr_a_r != 32'h00000000 && load_r >= thr_a_r;
        events[EV_LOAD_B] = thr_b_r != 32'h00000000 && load_r >= thr_b_r;
        events[EV_TRIP]   = travel_r.trip > 32'(trip_thr_r * REV_PER_UNIT);
        events[EV_TOTAL]  = travel_r.total > 32'(total_thr_r * REV_PER_UNIT);
        events[EV_SAVED]  = nvm_save_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            info_o <= '0;
        end else begin
            info_o <= events;
        end
    end

    // sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_r <= '0;
        end else if (wr_access && wb_adr_i == OFS_IRQ_CLEAR && wb_sel_i[0]) begin
            status_r <= (status_r & ~wb_dat_i[EV_W-1:0]) | events;
        end else begin
            status_r <= status_r | events;
        end
    end
    assign irq_o = |(status_r & enable_r);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_load_saturate: assert property (load_r == LOAD_MAX && !load_clear |=> load_r == LOAD_MAX)
        else $error("load counter left its ceiling");
    a_load_step: assert property (!load_clear |=> load_r - $past(load_r) <= 32'h00000001)
        else $error("load grew by more than one count");
    a_divide_count: assert property (!load_clear && !drain |=> load_r == $past(load_r))
        else $error("load counted without a full divisor of area");
    a_auto_clear: assert property (auto_clear_r && motion_active_i && !motion_q_r |=> load_r == 0)
        else $error("motion start did not clear load");
    a_manual_keep: assert property (!auto_clear_r && motion_active_i && !motion_q_r
                                    && !(latch_clear_input_i && !latch_q_r) |=> load_r >= $past(load_r))
        else $error("load cleared by motion with auto-clear off");
    a_latch_clear: assert property (!auto_clear_r && latch_clear_input_i && !latch_q_r |=> load_r == 0)
        else $error("latch clear did not clear load");
    a_flag_a: assert property (thr_a_r != 0 && load_r >= thr_a_r |=> status_r[EV_LOAD_A] && info_o[EV_LOAD_A])
        else $error("threshold a not flagged");
    a_flag_b: assert property (thr_b_r != 0 && load_r >= thr_b_r |=> status_r[EV_LOAD_B])
        else $error("threshold b not flagged");
    a_save_period: assert property (nvm_save_o |-> $past(save_cnt_r) == SAVE_W'(SAVE_PERIOD - 1)
                                    && nvm_save_data_o == $past(travel_r))
        else $error("storage copy out of period or stale");
    a_trip_clear: assert property (trip_clear && !nvm_restore_i |=> travel_r.trip == 0
                                   && travel_r.total >= $past(travel_r.total))
        else $error("trip clear wrong");
    a_travel_flag: assert property (travel_r.trip > 32'(trip_thr_r * REV_PER_UNIT) |=> status_r[EV_TRIP])
        else $error("trip threshold not flagged");
    a_total_restore: assert property (nvm_restore_i |=> travel_r.total == $past(nvm_restore_data_i.total))
        else $error("total travel not restored");

endmodule // wear_meter

`default_nettype wire

// ==== tb/motor_meas_model.sv ====
// partner model: motor drive measurements and non-volatile travel store
`timescale 1ns/1ps
`default_nettype none
module motor_meas_model
    import wear_meter_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // bench commands
    input  wire logic       run_i,
    input  wire logic       latch_i,
    input  wire logic [9:0] load_i,
    input  wire logic [7:0] revs_i,
    input  wire logic       go_i,
    input  wire logic       restore_i,
    // toward the meters
    output logic            motion_active_o,
    output logic            latch_clear_o,
    output logic [9:0]      load_factor_o,
    output logic            rev_tick_o,
    output logic            nvm_restore_o,
    output travel_s         nvm_restore_data_o,
    input  wire logic       nvm_save_i,
    input  wire travel_s    nvm_save_data_i
);
    logic [7:0] revs_left_r;
    travel_s    store_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            motion_active_o <= 1'b0;
            latch_clear_o   <= 1'b0;
            load_factor_o   <= 10'h000;
            nvm_restore_o   <= 1'b0;
        end else begin
            motion_active_o <= run_i;
            latch_clear_o   <= latch_i;
            load_factor_o   <= run_i ? load_i : 10'h000;
            nvm_restore_o   <= restore_i;
        end
    end

    // one revolution every other cycle until the requested count is spent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            revs_left_r <= 8'h00;
            rev_tick_o  <= 1'b0;
        end else if (go_i) begin
            revs_left_r <= revs_i;
            rev_tick_o  <= 1'b0;
        end else if (revs_left_r != 8'h00 && !rev_tick_o) begin
            revs_left_r <= revs_left_r - 8'h01;
            rev_tick_o  <= 1'b1;
        end else begin
            rev_tick_o  <= 1'b0;
        end
    end

    // store has no reset: it must outlive a power cycle of the meters
    always_ff @(posedge clk_i) begin
        if (nvm_save_i) begin
            store_r <= nvm_save_data_i;
        end
    end

    // outside a restore pulse the data lines carry nothing trustworthy
    assign nvm_restore_data_o = nvm_restore_o ? store_r : ~store_r;
endmodule // motor_meas_model
`default_nettype wire

// ==== tb/wear_meter_tb_top.sv ====
// self-checking bench for the load and travel maintenance meters
`timescale 1ns/1ps
`default_nettype none
module wear_meter_tb_top
    import wear_meter_pkg::*;
;
    typedef struct packed {
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } row_s;
    localparam row_s ROWS [0:14] = '{
        '{1'b0, OFS_CTRL, 4'hF, 32'h00000001}, '{1'b0, OFS_DIVISOR, 4'hF, 32'h00000001},
        '{1'b0, OFS_THR_A, 4'hF, RST_THR_A}, '{1'b0, OFS_TRIP_THR, 4'hF, RST_TRIP_THR},
        '{1'b0, OFS_TOTAL_THR, 4'hF, RST_TOTAL_THR}, '{1'b0, OFS_IRQ_ENABLE, 4'hF, 32'h0},
        '{1'b1, OFS_THR_B, 4'hF, 32'h12345678}, '{1'b1, OFS_THR_B, 4'h2, 32'h0000AB00},
        '{1'b0, OFS_THR_B, 4'hF, 32'h1234AB78}, '{1'b1, OFS_LOAD, 4'hF, 32'hFFFFFFFF},
        '{1'b0, OFS_LOAD, 4'hF, 32'h0}, '{1'b1, 8'h30, 4'hF, 32'hFFFFFFFF},
        '{1'b0, 8'h30, 4'hF, 32'h0}, '{1'b0, OFS_IRQ_CLEAR, 4'hF, 32'h0},
        '{1'b1, OFS_THR_B, 4'hF, 32'h0}};

    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, run, latch, go, restore;
    logic motion_active, latch_clear, rev_tick, nvm_restore, nvm_save_o, irq_o;
    logic [7:0]      wb_adr_i, revs;
    logic [3:0]      wb_sel_i;
    logic [31:0]     wb_dat_i, wb_dat_o, q;
    logic [9:0]      load, load_factor;
    logic [EV_W-1:0] info_o;
    travel_s         nvm_restore_data, nvm_save_data_o;
    int              n_fail, check_count, n;

    wear_meter #(.SAMPLE_PERIOD(8), .SAVE_PERIOD(50)) wear_meter_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .motion_active_i(motion_active), .latch_clear_input_i(latch_clear), .load_factor_i(load_factor),
        .rev_tick_i(rev_tick), .nvm_restore_i(nvm_restore), .nvm_restore_data_i(nvm_restore_data),
        .nvm_save_o(nvm_save_o), .nvm_save_data_o(nvm_save_data_o), .info_o(info_o), .irq_o(irq_o));
    motor_meas_model motor_meas_model_inst (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .latch_i(latch),
        .load_i(load), .revs_i(revs), .go_i(go), .restore_i(restore), .motion_active_o(motion_active),
        .latch_clear_o(latch_clear), .load_factor_o(load_factor), .rev_tick_o(rev_tick),
        .nvm_restore_o(nvm_restore), .nvm_restore_data_o(nvm_restore_data), .nvm_save_i(nvm_save_o),
        .nvm_save_data_i(nvm_save_data_o));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // classic cycle, entered just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] r);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            k++;
            if (k > 20) begin
                n_fail++;
                complete_run();
            end
            @(posedge clk_i);
        end
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, 4'hF, d, r);
    endtask

    task automatic poll(input logic [7:0] a, input logic [31:0] e);
        int k;
        k = 0;
        wb(1'b0, a, 4'hF, 32'h0, q);
        while (q !== e && k < 100) begin
            wb(1'b0, a, 4'hF, 32'h0, q);
            k++;
        end
        check(q, e);
        if (q !== e) complete_run();
    endtask

    // exactly ten time-base ticks fall in any 80 cycles
    task automatic burst();
        load <= 10'h00A;
        repeat (80) @(posedge clk_i);
        load <= 10'h000;
    endtask

    initial begin
        rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 8'h00;
        wb_sel_i = 4'h0; wb_dat_i = 32'h0; run = 1'b0; latch = 1'b0; load = 10'h000;
        revs = 8'h00; go = 1'b0; restore = 1'b0; n_fail = 0; check_count = 0;
        repeat (12) @(posedge clk_i);
        check(32'({irq_o, nvm_save_o, wb_ack_o, info_o}), 32'h0);
        check(wb_dat_o, 32'h0);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (ROWS[i]) begin
            wb(ROWS[i].we, ROWS[i].adr, ROWS[i].sel, ROWS[i].dat, q);
            if (!ROWS[i].we) check(q, ROWS[i].dat);
        end
        run <= 1'b1;
        repeat (4) @(posedge clk_i);
        burst();
        poll(OFS_LOAD, 32'd100);
        wr(OFS_THR_A, 32'd20);
        wr(OFS_THR_B, 32'd1000);
        wr(OFS_IRQ_ENABLE, 32'h3);
        // periodic save event has long been latched in bit 4
        poll(OFS_IRQ_STATUS, 32'h11);
        check(32'(irq_o), 32'h1);
        check(32'(info_o[1:0]), 32'h1);
        run <= 1'b0;
        repeat (2) @(posedge clk_i);
        run <= 1'b1;
        poll(OFS_LOAD, 32'h0);
        wr(OFS_IRQ_CLEAR, 32'h3);
        wb(1'b0, OFS_IRQ_STATUS, 4'hF, 32'h0, q);
        check(q & 32'h3, 32'h0);
        check(32'(irq_o), 32'h0);
        wr(OFS_DIVISOR, 32'd5);
        burst();
        poll(OFS_LOAD, 32'd20);
        wr(OFS_CTRL, 32'h0);
        run <= 1'b0;
        repeat (2) @(posedge clk_i);
        run <= 1'b1;
        repeat (4) @(posedge clk_i);
        wb(1'b0, OFS_LOAD, 4'hF, 32'h0, q);
        check(q, 32'd20);
        latch <= 1'b1;
        poll(OFS_LOAD, 32'h0);
        latch <= 1'b0;
        // divisor 0 counts as divisor 1
        wr(OFS_DIVISOR, 32'h0);
        burst();
        poll(OFS_LOAD, 32'd100);
        wr(OFS_THR_B, 32'd50);
        wb(1'b0, OFS_IRQ_STATUS, 4'hF, 32'h0, q);
        check(q & 32'h3, 32'h3);
        check(32'(info_o[1:0]), 32'h3);
        // travel flag boundary: 100 revs equals one unit, not above it
        wr(OFS_TRIP_THR, 32'h1);
        wr(OFS_TOTAL_THR, 32'h1);
        revs <= 8'd100;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        poll(OFS_TRIP, 32'd100);
        wr(OFS_IRQ_CLEAR, 32'h1F);
        wb(1'b0, OFS_IRQ_STATUS, 4'hF, 32'h0, q);
        check(q & 32'hC, 32'h0);
        revs <= 8'd1;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        poll(OFS_TRIP, 32'd101);
        wb(1'b0, OFS_IRQ_STATUS, 4'hF, 32'h0, q);
        check(q & 32'hC, 32'hC);
        check(32'(info_o[3:2]), 32'h3);
        wr(OFS_CTRL, 32'h2);
        poll(OFS_TRIP, 32'h0);
        wb(1'b0, OFS_TOTAL, 4'hF, 32'h0, q);
        check(q, 32'd101);
        n = 0;
        while (nvm_save_o !== 1'b1 && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        check(32'(nvm_save_o), 32'h1);
        check(nvm_save_data_o.trip, 32'h0);
        check(nvm_save_data_o.total, 32'd101);
        // power cycle: restore must land before the first save after release
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        check(32'({irq_o, nvm_save_o, wb_ack_o, info_o}), 32'h0);
        check(nvm_save_data_o.total, 32'h0);
        rst_i <= 1'b0;
        restore <= 1'b1;
        @(posedge clk_i);
        restore <= 1'b0;
        poll(OFS_TOTAL, 32'd101);
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        complete_run();
    end
endmodule // wear_meter_tb_top
`default_nettype wire
